// file: common/eif_pkg.sv
// shared constants and types for the external interrupt edge and noise filter block
package eif_pkg;

   // register byte addresses on the avalon bus
   localparam logic [31:0] EIF_ADDR_LOW_FALL = 32'hffff_f300;
   localparam logic [31:0] EIF_ADDR_LOW_RISE = 32'hffff_f304;
   localparam logic [31:0] EIF_ADDR_P7_FALL = 32'hffff_f308;
   localparam logic [31:0] EIF_ADDR_P7_RISE = 32'hffff_f30c;
   localparam logic [31:0] EIF_ADDR_P46_FALL = 32'hffff_f310;
   localparam logic [31:0] EIF_ADDR_P46_RISE = 32'hffff_f314;
   localparam logic [31:0] EIF_ADDR_NFC = 32'hffff_f318;
   localparam logic [31:0] EIF_ADDR_IRQ_STAT = 32'hffff_f31c;
   localparam logic [31:0] EIF_ADDR_IRQ_EN = 32'hffff_f320;
   localparam logic [31:0] EIF_ADDR_IRQ_CLR = 32'hffff_f324;
   localparam logic [31:0] EIF_ADDR_BITOP = 32'hffff_f328;

   // implemented bits of each 8-bit register, the rest read as zero
   localparam logic [7:0] EIF_MASK_LOW = 8'h7c;
   localparam logic [7:0] EIF_MASK_P7 = 8'h02;
   localparam logic [7:0] EIF_MASK_P46 = 8'he0;
   localparam logic [7:0] EIF_MASK_NFC = 8'h87;
   localparam logic [7:0] EIF_MASK_IRQ = 8'h1f;

   // reset values
   localparam logic [7:0] EIF_EDGE_RST = 8'h00;
   localparam logic [7:0] EIF_NFC_RST = 8'h00;
   localparam logic [7:0] EIF_IRQ_RST = 8'h00;

   // field positions
   localparam int EIF_PIN3_BIT = 6;
   localparam int EIF_PIN7_BIT = 1;
   localparam int EIF_PIN4_BIT = 5;
   localparam int EIF_NFC_DFILT_BIT = 7;
   localparam int EIF_NFC_SEL_LSB = 0;
   localparam int EIF_BITOP_SEL_LSB = 4;
   localparam int EIF_BITOP_VAL_BIT = 8;

   // interrupt status layout: bit 0 is pin three up to bit 4 for pin seven
   localparam int EIF_NUM_PINS = 5;

   // bit-operation register select codes
   localparam logic [2:0] EIF_BSEL_LOW_FALL = 3'h0;
   localparam logic [2:0] EIF_BSEL_LOW_RISE = 3'h1;
   localparam logic [2:0] EIF_BSEL_P7_FALL = 3'h2;
   localparam logic [2:0] EIF_BSEL_P7_RISE = 3'h3;
   localparam logic [2:0] EIF_BSEL_P46_FALL = 3'h4;
   localparam logic [2:0] EIF_BSEL_P46_RISE = 3'h5;

   // timing: digital filter agreement count, prescaler width
   localparam logic [1:0] EIF_FILT_SAMPLES = 2'h3;
   localparam int EIF_PRESC_W = 10;

   // digital sampling clock choices
   typedef enum logic [2:0] {
      EIF_SMP_DIV64 = 3'h0,
      EIF_SMP_DIV128 = 3'h1,
      EIF_SMP_DIV256 = 3'h2,
      EIF_SMP_DIV512 = 3'h3,
      EIF_SMP_DIV1024 = 3'h4,
      EIF_SMP_SUB = 3'h5
   } eif_smp_sel_type;

endpackage

// file: hdl/eif_sync.sv
// three-stage pin synchroniser whose output moves once stages two and three agree
`timescale 1ns/1ps
module eif_sync (
   input wire logic core_clk_i, // peripheral clock
   input wire logic rstn_i, // synchronous reset, active low
   input wire logic pin_i, // asynchronous pin level
   output logic level_o // filtered synchronous level
);
   import eif_pkg::*;

   logic s1_reg, s2_reg, s3_reg, lvl_reg;
   logic lvl_next;

   // stage one feeds stage two only, to keep metastability contained
   always_comb begin
      lvl_next = lvl_reg;
      if (s2_reg == s3_reg) begin
         lvl_next = s3_reg;
      end
   end

   // register stages
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         lvl_reg <= 1'b0;
      end else begin
         s1_reg <= pin_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         lvl_reg <= lvl_next;
      end
   end

   assign level_o = lvl_reg;
endmodule

// file: hdl/eif_edge_det.sv
// per-pin valid edge detector producing a one-cycle request pulse
`timescale 1ns/1ps
module eif_edge_det (
   input wire logic core_clk_i, // peripheral clock
   input wire logic rstn_i, // synchronous reset, active low
   input wire logic level_i, // conditioned pin level, same clock
   input wire logic fall_sel_i, // detect falling edges
   input wire logic rise_sel_i, // detect rising edges
   output logic req_o // one-cycle request pulse
);
   import eif_pkg::*;

   logic prev_reg, req_reg;
   logic prev_next, req_next;

   // 00 none, 01 rising, 10 falling, 11 both
   always_comb begin
      prev_next = level_i;
      req_next = (rise_sel_i && level_i && !prev_reg) ||
                 (fall_sel_i && !level_i && prev_reg);
   end

   // registered so the request is a clean single-cycle pulse
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         prev_reg <= 1'b0;
         req_reg <= 1'b0;
      end else begin
         prev_reg <= prev_next;
         req_reg <= req_next;
      end
   end

   assign req_o = req_reg;
endmodule

// file: hdl/eif_top.sv
// external interrupt pin conditioning: edge select, pin three noise filter, avalon registers
//
// How it works
// - pin seven edge: 00 none,01 rise,10 fall,11 both
// - pins four to six use bits 5-7
// - edge select registers reset to zero
// - edge selects writable as byte or bit
// - filter bit seven: 0 analog, 1 digital
// - sample clock: divide 64..1024 or subclock
// - three matching samples accept a new level
// - pulses up to two samples rejected
// - subclock sampling still wakes from standby
// - sample clock change needs three samples
// - noise control byte-only, resets zero, reserved zero
// - pin three edge in low pair bit six
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module eif_top (
   input wire logic core_clk_i, // peripheral clock, 50 MHz
   input wire logic rstn_i, // synchronous reset, active low
   input wire logic [31:0] avs_address_i, // avalon byte address
   input wire logic avs_read_i, // avalon read
   input wire logic avs_write_i, // avalon write
   input wire logic [31:0] avs_writedata_i, // avalon write data
   input wire logic [3:0] avs_byteenable_i, // avalon byte enables
   output logic [31:0] avs_readdata_o, // avalon read data
   output logic avs_waitrequest_o, // avalon wait request
   input wire logic ext_irq_in_three_i, // pin three, filtered
   input wire logic ext_irq_in_four_i, // pin four
   input wire logic ext_irq_in_five_i, // pin five
   input wire logic ext_irq_in_six_i, // pin six
   input wire logic ext_irq_in_seven_i, // pin seven
   input wire logic sub_clock_i, // subclock, sampled as a pin
   input wire logic standby_i, // divided sample clocks stopped
   output logic [eif_pkg::EIF_NUM_PINS-1:0] irq_req_o, // request pulses, pins 3..7
   output logic pin3_wake_o, // pin three standby release pulse
   output logic irq_o // level interrupt
);
   import eif_pkg::*;

   // register state
   logic [7:0] low_fall_edge_sel_reg, low_fall_edge_sel_next;
   logic [7:0] low_rise_edge_sel_reg, low_rise_edge_sel_next;
   logic [7:0] pin7_fall_edge_sel_reg, pin7_fall_edge_sel_next;
   logic [7:0] pin7_rise_edge_sel_reg, pin7_rise_edge_sel_next;
   logic [7:0] pins4to6_fall_edge_sel_reg, pins4to6_fall_edge_sel_next;
   logic [7:0] pins4to6_rise_edge_sel_reg, pins4to6_rise_edge_sel_next;
   logic [7:0] noise_filter_ctrl_reg, noise_filter_ctrl_next;
   logic [7:0] irq_stat_reg, irq_stat_next;
   logic [7:0] irq_en_reg, irq_en_next;
   logic irq_reg, irq_next;
   logic wait_reg, wait_next;
   logic [31:0] rdata_reg, rdata_next;

   // filter state
   logic [EIF_PRESC_W-1:0] presc_reg, presc_next;
   logic sub_prev_reg, sub_prev_next;
   logic [2:0] hist_reg, hist_next;
   logic [1:0] cnt_reg, cnt_next;
   logic filt_reg, filt_next;
   logic wake_reg, wake_next;

   logic req_any, wr_done;
   logic [7:0] wmask;
   logic [2:0] bsel;
   logic [2:0] bpos;
   logic bval;
   logic [7:0] bone;
   logic sel_change;
   logic div_tick, sub_tick, smp_tick;
   logic digital_mode;
   eif_smp_sel_type smp_sel;
   logic [EIF_NUM_PINS-1:0] pin_sync;
   logic [EIF_NUM_PINS-1:0] pin_cond;
   logic [EIF_NUM_PINS-1:0] fall_sel, rise_sel;
   logic [EIF_NUM_PINS-1:0] req;
   logic sub_sync;

   // every pin passes a synchroniser before any logic looks at it
   eif_sync u_sync_p3 (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
      .pin_i(ext_irq_in_three_i), .level_o(pin_sync[0]));
   eif_sync u_sync_p4 (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
      .pin_i(ext_irq_in_four_i), .level_o(pin_sync[1]));
   eif_sync u_sync_p5 (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
      .pin_i(ext_irq_in_five_i), .level_o(pin_sync[2]));
   eif_sync u_sync_p6 (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
      .pin_i(ext_irq_in_six_i), .level_o(pin_sync[3]));
   eif_sync u_sync_p7 (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
      .pin_i(ext_irq_in_seven_i), .level_o(pin_sync[4]));
   eif_sync u_sync_sub (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
      .pin_i(sub_clock_i), .level_o(sub_sync));

   // per-pin select bits
   assign fall_sel[0] = low_fall_edge_sel_reg[EIF_PIN3_BIT];
   assign rise_sel[0] = low_rise_edge_sel_reg[EIF_PIN3_BIT];
   assign fall_sel[3:1] = pins4to6_fall_edge_sel_reg[EIF_PIN4_BIT +: 3];
   assign rise_sel[3:1] = pins4to6_rise_edge_sel_reg[EIF_PIN4_BIT +: 3];
   assign fall_sel[4] = pin7_fall_edge_sel_reg[EIF_PIN7_BIT];
   assign rise_sel[4] = pin7_rise_edge_sel_reg[EIF_PIN7_BIT];

   // pin three takes the filtered level in digital mode, others run straight
   assign digital_mode = noise_filter_ctrl_reg[EIF_NFC_DFILT_BIT];
   assign pin_cond = {pin_sync[4:1], digital_mode ? filt_reg : pin_sync[0]};

   // one detector per pin
   genvar gi;
   generate
      for (gi = 0; gi < EIF_NUM_PINS; gi++) begin : g_det
         eif_edge_det u_det (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
            .level_i(pin_cond[gi]), .fall_sel_i(fall_sel[gi]),
            .rise_sel_i(rise_sel[gi]), .req_o(req[gi]));
      end
   endgenerate

   // bus decode helpers
   assign req_any = avs_read_i || avs_write_i;
   assign wr_done = avs_write_i && !wait_reg;
   assign wmask = avs_byteenable_i[0] ? 8'hff : 8'h00;
   assign bsel = avs_writedata_i[EIF_BITOP_SEL_LSB +: 3];
   assign bpos = avs_writedata_i[2:0];
   assign bval = avs_writedata_i[EIF_BITOP_VAL_BIT];
   assign bone = 8'h01 << bpos;

   // sample clock: divided core clock or subclock rising edges
   assign smp_sel = eif_smp_sel_type'(noise_filter_ctrl_reg[EIF_NFC_SEL_LSB +: 3]);
   assign sub_tick = sub_sync && !sub_prev_reg;
   always_comb begin
      div_tick = 1'b0;
      unique case (smp_sel)
         EIF_SMP_DIV64: div_tick = &presc_reg[5:0];
         EIF_SMP_DIV128: div_tick = &presc_reg[6:0];
         EIF_SMP_DIV256: div_tick = &presc_reg[7:0];
         EIF_SMP_DIV512: div_tick = &presc_reg[8:0];
         EIF_SMP_DIV1024: div_tick = &presc_reg[9:0];
         EIF_SMP_SUB: div_tick = 1'b0;
         default: div_tick = 1'b0; // prohibited codes never sample
      endcase
   end
   // divided clocks stop in standby, the subclock keeps running
   assign smp_tick = (smp_sel == EIF_SMP_SUB) ? sub_tick : (div_tick && !standby_i);

   // a write that changes the sample clock code restarts the filter
   assign sel_change = wr_done && (avs_address_i == EIF_ADDR_NFC) && avs_byteenable_i[0] &&
      (avs_writedata_i[EIF_NFC_SEL_LSB +: 3] != noise_filter_ctrl_reg[EIF_NFC_SEL_LSB +: 3]);

   // digital filter next state
   always_comb begin
      presc_next = presc_reg + 1'b1;
      sub_prev_next = sub_sync;
      hist_next = hist_reg;
      cnt_next = cnt_reg;
      filt_next = filt_reg;
      if (!digital_mode) begin
         filt_next = pin_sync[0]; // track, so entering digital mode makes no edge
      end
      if (sel_change) begin
         cnt_next = 2'h0;
      end else if (digital_mode && smp_tick) begin
         hist_next = {hist_reg[1:0], pin_sync[0]};
         if (cnt_reg != EIF_FILT_SAMPLES) begin
            cnt_next = cnt_reg + 2'h1;
         end
         // level accepted only after three agreeing samples; narrower pulses lost
         if ((cnt_reg >= EIF_FILT_SAMPLES - 2'h1) && (hist_reg[1] == pin_sync[0]) &&
             (hist_reg[0] == pin_sync[0])) begin
            filt_next = pin_sync[0];
         end
      end
      wake_next = standby_i && req[0];
   end

   // register file next values
   always_comb begin
      low_fall_edge_sel_next = low_fall_edge_sel_reg;
      low_rise_edge_sel_next = low_rise_edge_sel_reg;
      pin7_fall_edge_sel_next = pin7_fall_edge_sel_reg;
      pin7_rise_edge_sel_next = pin7_rise_edge_sel_reg;
      pins4to6_fall_edge_sel_next = pins4to6_fall_edge_sel_reg;
      pins4to6_rise_edge_sel_next = pins4to6_rise_edge_sel_reg;
      noise_filter_ctrl_next = noise_filter_ctrl_reg;
      irq_en_next = irq_en_reg;
      irq_stat_next = irq_stat_reg | {3'h0, req}; // sticky set
      if (wr_done) begin
         unique case (avs_address_i)
            EIF_ADDR_LOW_FALL: low_fall_edge_sel_next =
               (low_fall_edge_sel_reg & ~wmask) | (avs_writedata_i[7:0] & wmask & EIF_MASK_LOW);
            EIF_ADDR_LOW_RISE: low_rise_edge_sel_next =
               (low_rise_edge_sel_reg & ~wmask) | (avs_writedata_i[7:0] & wmask & EIF_MASK_LOW);
            EIF_ADDR_P7_FALL: pin7_fall_edge_sel_next =
               (pin7_fall_edge_sel_reg & ~wmask) | (avs_writedata_i[7:0] & wmask & EIF_MASK_P7);
            EIF_ADDR_P7_RISE: pin7_rise_edge_sel_next =
               (pin7_rise_edge_sel_reg & ~wmask) | (avs_writedata_i[7:0] & wmask & EIF_MASK_P7);
            EIF_ADDR_P46_FALL: pins4to6_fall_edge_sel_next =
               (pins4to6_fall_edge_sel_reg & ~wmask) | (avs_writedata_i[7:0] & wmask & EIF_MASK_P46);
            EIF_ADDR_P46_RISE: pins4to6_rise_edge_sel_next =
               (pins4to6_rise_edge_sel_reg & ~wmask) | (avs_writedata_i[7:0] & wmask & EIF_MASK_P46);
            // whole byte only; reserved bits six to three stay zero
            EIF_ADDR_NFC: noise_filter_ctrl_next = avs_byteenable_i[0] ?
               (avs_writedata_i[7:0] & EIF_MASK_NFC) : noise_filter_ctrl_reg;
            EIF_ADDR_IRQ_EN: irq_en_next =
               (irq_en_reg & ~wmask) | (avs_writedata_i[7:0] & wmask & EIF_MASK_IRQ);
            // clear first, then the same cycle's events set again: set wins
            EIF_ADDR_IRQ_CLR: irq_stat_next =
               (irq_stat_reg & ~(avs_writedata_i[7:0] & wmask)) | {3'h0, req};
            // single-bit write into an edge select register; the filter register is not reachable
            EIF_ADDR_BITOP: begin
               if (avs_byteenable_i[0] && avs_byteenable_i[1]) begin
                  unique case (bsel)
                     EIF_BSEL_LOW_FALL: low_fall_edge_sel_next = EIF_MASK_LOW &
                        (bval ? (low_fall_edge_sel_reg | bone) : (low_fall_edge_sel_reg & ~bone));
                     EIF_BSEL_LOW_RISE: low_rise_edge_sel_next = EIF_MASK_LOW &
                        (bval ? (low_rise_edge_sel_reg | bone) : (low_rise_edge_sel_reg & ~bone));
                     EIF_BSEL_P7_FALL: pin7_fall_edge_sel_next = EIF_MASK_P7 &
                        (bval ? (pin7_fall_edge_sel_reg | bone) : (pin7_fall_edge_sel_reg & ~bone));
                     EIF_BSEL_P7_RISE: pin7_rise_edge_sel_next = EIF_MASK_P7 &
                        (bval ? (pin7_rise_edge_sel_reg | bone) : (pin7_rise_edge_sel_reg & ~bone));
                     EIF_BSEL_P46_FALL: pins4to6_fall_edge_sel_next = EIF_MASK_P46 &
                        (bval ? (pins4to6_fall_edge_sel_reg | bone) :
                        (pins4to6_fall_edge_sel_reg & ~bone));
                     EIF_BSEL_P46_RISE: pins4to6_rise_edge_sel_next = EIF_MASK_P46 &
                        (bval ? (pins4to6_rise_edge_sel_reg | bone) :
                        (pins4to6_rise_edge_sel_reg & ~bone));
                     default: ; // unused select codes are ignored
                  endcase
               end
            end
            default: ; // unmapped writes are dropped
         endcase
      end
      irq_next = |(irq_stat_next & irq_en_next);
   end

   // bus handshake: one wait cycle, then the request completes
   always_comb begin
      wait_next = !(req_any && wait_reg);
      rdata_next = rdata_reg;
      if (req_any && wait_reg) begin
         rdata_next = 32'h0000_0000;
         if (avs_read_i) begin
            unique case (avs_address_i)
               EIF_ADDR_LOW_FALL: rdata_next[7:0] = low_fall_edge_sel_reg;
               EIF_ADDR_LOW_RISE: rdata_next[7:0] = low_rise_edge_sel_reg;
               EIF_ADDR_P7_FALL: rdata_next[7:0] = pin7_fall_edge_sel_reg;
               EIF_ADDR_P7_RISE: rdata_next[7:0] = pin7_rise_edge_sel_reg;
               EIF_ADDR_P46_FALL: rdata_next[7:0] = pins4to6_fall_edge_sel_reg;
               EIF_ADDR_P46_RISE: rdata_next[7:0] = pins4to6_rise_edge_sel_reg;
               EIF_ADDR_NFC: rdata_next[7:0] = noise_filter_ctrl_reg;
               EIF_ADDR_IRQ_STAT: rdata_next[7:0] = irq_stat_reg;
               EIF_ADDR_IRQ_EN: rdata_next[7:0] = irq_en_reg;
               default: rdata_next = 32'h0000_0000; // write-only and unmapped read zero
            endcase
         end
      end
   end

   // all state registers
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         low_fall_edge_sel_reg <= EIF_EDGE_RST;
         low_rise_edge_sel_reg <= EIF_EDGE_RST;
         pin7_fall_edge_sel_reg <= EIF_EDGE_RST;
         pin7_rise_edge_sel_reg <= EIF_EDGE_RST;
         pins4to6_fall_edge_sel_reg <= EIF_EDGE_RST;
         pins4to6_rise_edge_sel_reg <= EIF_EDGE_RST;
         noise_filter_ctrl_reg <= EIF_NFC_RST;
         irq_stat_reg <= EIF_IRQ_RST;
         irq_en_reg <= EIF_IRQ_RST;
         irq_reg <= 1'b0;
         wait_reg <= 1'b1;
         rdata_reg <= 32'h0000_0000;
         presc_reg <= '0;
         sub_prev_reg <= 1'b0;
         hist_reg <= 3'h0;
         cnt_reg <= 2'h0;
         filt_reg <= 1'b0;
         wake_reg <= 1'b0;
      end else begin
         low_fall_edge_sel_reg <= low_fall_edge_sel_next;
         low_rise_edge_sel_reg <= low_rise_edge_sel_next;
         pin7_fall_edge_sel_reg <= pin7_fall_edge_sel_next;
         pin7_rise_edge_sel_reg <= pin7_rise_edge_sel_next;
         pins4to6_fall_edge_sel_reg <= pins4to6_fall_edge_sel_next;
         pins4to6_rise_edge_sel_reg <= pins4to6_rise_edge_sel_next;
         noise_filter_ctrl_reg <= noise_filter_ctrl_next;
         irq_stat_reg <= irq_stat_next;
         irq_en_reg <= irq_en_next;
         irq_reg <= irq_next;
         wait_reg <= wait_next;
         rdata_reg <= rdata_next;
         presc_reg <= presc_next;
         sub_prev_reg <= sub_prev_next;
         hist_reg <= hist_next;
         cnt_reg <= cnt_next;
         filt_reg <= filt_next;
         wake_reg <= wake_next;
      end
   end

   // outputs straight from flops
   assign avs_readdata_o = rdata_reg;
   assign avs_waitrequest_o = wait_reg;
   assign irq_req_o = req;
   assign pin3_wake_o = wake_reg;
   assign irq_o = irq_reg;
endmodule

// file: verif/eif_pins_model.sv
// board-side model of the external interrupt pins and the subclock
`timescale 1ns/1ps
module eif_pins_model #(
   parameter int SUB_HALF = 6 // subclock half period in core cycles
) (
   input wire logic core_clk_i, // core clock, pins move just after its edges
   output logic [4:0] pins_o, // pins three to seven
   output logic sub_clock_o // subclock oscillator
);
   int sub_cnt = 0;
   initial begin
      pins_o = 5'h00;
      sub_clock_o = 1'b0;
   end
   // subclock keeps running in standby, unlike the divided clocks
   always @(posedge core_clk_i) begin
      sub_cnt <= (sub_cnt == SUB_HALF - 1) ? 0 : sub_cnt + 1;
      if (sub_cnt == SUB_HALF - 1) sub_clock_o <= ~sub_clock_o;
   end
   // pin seven only ever acts as an interrupt input here, never as receive data
   task automatic drive(input int idx, input logic lvl, input int hold);
      pins_o[idx] <= lvl;
      repeat (hold) @(posedge core_clk_i);
   endtask
endmodule

// file: verif/eif_top_assertions.sv
// port-level checks for the external interrupt conditioning block
`timescale 1ns/1ps
module eif_top_assertions (
   input wire logic core_clk_i, // peripheral clock
   input wire logic rstn_i, // synchronous reset, active low
   input wire logic avs_read_i, // avalon read
   input wire logic avs_write_i, // avalon write
   input wire logic [31:0] avs_readdata_o, // avalon read data
   input wire logic avs_waitrequest_o, // avalon wait request
   input wire logic [eif_pkg::EIF_NUM_PINS-1:0] irq_req_o, // request pulses
   input wire logic pin3_wake_o, // standby release pulse
   input wire logic irq_o // level interrupt
);
   import eif_pkg::*;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rstn_i);
   // a request seen while wait is high completes next cycle, then wait returns
   sequence s_req_seen;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence
   sequence s_done;
      !avs_waitrequest_o ##1 avs_waitrequest_o;
   endsequence
   property p_answer;
      s_req_seen |=> s_done;
   endproperty
   a_answer: assert property (p_answer) else $error("bus request not answered");
   property p_wait_cause;
      !avs_waitrequest_o |-> $past(avs_read_i || avs_write_i);
   endproperty
   a_wait_cause: assert property (p_wait_cause) else $error("wait dropped unasked");
   property p_rdata_hi;
      avs_readdata_o[31:8] == 24'h00_0000;
   endproperty
   a_rdata_hi: assert property (p_rdata_hi) else $error("read data upper bits set");
   // read data may only move on a completion
   property p_rdata_hold;
      avs_waitrequest_o && $past(avs_waitrequest_o) |-> $stable(avs_readdata_o);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   property p_req_pulse;
      (irq_req_o != '0) |=> ((irq_req_o & $past(irq_req_o)) == '0);
   endproperty
   a_req_pulse: assert property (p_req_pulse) else $error("request longer than a cycle");
   property p_wake;
      pin3_wake_o |-> (irq_req_o[0] || $past(irq_req_o[0]));
   endproperty
   a_wake: assert property (p_wake) else $error("wake without pin three request");
   property p_irq_rise;
      $rose(irq_o) |-> ($past(irq_req_o) != '0) || ($past(irq_req_o, 2) != '0)
         || $past(avs_write_i) || $past(avs_write_i, 2);
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose without cause");
   property p_irq_fall;
      $fell(irq_o) |-> $past(avs_write_i) || $past(avs_write_i, 2);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without write");
endmodule

// file: verif/ext_irq_edge_filter_bench.sv
// self-checking bench for the external interrupt conditioning block
`timescale 1ns/1ps
module ext_irq_edge_filter_bench;
   import eif_pkg::*;
   localparam int SUB_HALF = 6;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic [31:0] addr = '0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = '0;
   logic [3:0] be = 4'h1;
   logic standby = 1'b0;
   logic [31:0] rdata;
   logic waitreq;
   logic [4:0] req;
   logic wake;
   logic irq;
   logic [4:0] pins;
   logic sub_clk;
   logic [31:0] rv;
   int err_total = 0;
   int checks_done = 0;
   int cnt[5];
   int wake_cnt;
   // per pin (three to seven): falling select address and bit mask
   logic [31:0] fall_a[5] = '{EIF_ADDR_LOW_FALL, EIF_ADDR_P46_FALL, EIF_ADDR_P46_FALL,
      EIF_ADDR_P46_FALL, EIF_ADDR_P7_FALL};
   logic [7:0] mask[5] = '{8'h40, 8'h20, 8'h40, 8'h80, 8'h02};
   logic [7:0] regm[7] = '{EIF_MASK_LOW, EIF_MASK_LOW, EIF_MASK_P7, EIF_MASK_P7,
      EIF_MASK_P46, EIF_MASK_P46, EIF_MASK_NFC};
   int per[6] = '{64, 128, 256, 512, 1024, 2 * SUB_HALF};
   initial forever #10 core_clk = ~core_clk;
   eif_top eif_top_inst (.core_clk_i(core_clk), .rstn_i(rstn), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
      .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .ext_irq_in_three_i(pins[0]),
      .ext_irq_in_four_i(pins[1]), .ext_irq_in_five_i(pins[2]), .ext_irq_in_six_i(pins[3]),
      .ext_irq_in_seven_i(pins[4]), .sub_clock_i(sub_clk), .standby_i(standby),
      .irq_req_o(req), .pin3_wake_o(wake), .irq_o(irq));
   eif_pins_model #(.SUB_HALF(SUB_HALF)) eif_pins_model_inst (.core_clk_i(core_clk),
      .pins_o(pins), .sub_clock_o(sub_clk));
   // count request and wake pulses at each edge
   always @(posedge core_clk) begin
      for (int i = 0; i < 5; i++) if (req[i] === 1'b1) cnt[i]++;
      if (wake === 1'b1) wake_cnt++;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one avalon access; the extra edge keeps back-to-back requests apart
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
      input logic [3:0] b);
      addr <= a;
      wdata <= d;
      be <= b;
      rd <= !w;
      wr <= w;
      // no local limit: only the watchdog ends a hung access
      do begin
         @(posedge core_clk);
      end while (waitreq !== 1'b0);
      rv = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wreg(input logic [31:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'h1);
   endtask
   task automatic rreg(input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, 4'h1);
      check(rv, exp);
   endtask
   task automatic clr_cnt();
      foreach (cnt[i]) cnt[i] = 0;
      wake_cnt = 0;
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge core_clk);
      err_total++;
      end_of_test();
   end
   initial begin
      repeat (10) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      for (int k = 0; k < 7; k++) begin
         rreg(EIF_ADDR_LOW_FALL + 32'(4 * k), 32'h0);
         wreg(EIF_ADDR_LOW_FALL + 32'(4 * k), 32'hff);
         rreg(EIF_ADDR_LOW_FALL + 32'(4 * k), {24'h0, regm[k]});
         wreg(EIF_ADDR_LOW_FALL + 32'(4 * k), 32'h0);
      end
      bus(1'b1, EIF_ADDR_NFC, 32'h85, 4'h0);
      rreg(EIF_ADDR_NFC, 32'h0);
      bus(1'b1, EIF_ADDR_BITOP, 32'h0000_0131, 4'h3);
      rreg(EIF_ADDR_P7_RISE, 32'h02);
      bus(1'b1, EIF_ADDR_BITOP, 32'h0000_0031, 4'h3);
      rreg(EIF_ADDR_P7_RISE, 32'h0);
      wreg(32'hffff_f3f0, 32'hff);
      rreg(32'hffff_f3f0, 32'h0);
      $display("test registers done");
      // every edge code on every pin; selects cleared before and after use
      for (int p = 0; p < 5; p++) begin
         for (int c = 0; c < 4; c++) begin
            wreg(fall_a[p], c[1] ? {24'h0, mask[p]} : 32'h0);
            wreg(fall_a[p] + 32'h4, c[0] ? {24'h0, mask[p]} : 32'h0);
            clr_cnt();
            eif_pins_model_inst.drive(p, 1'b1, 12);
            check(cnt[p], {31'h0, c[0]});
            eif_pins_model_inst.drive(p, 1'b0, 12);
            check(cnt[p], {31'h0, c[0]} + {31'h0, c[1]});
            wreg(fall_a[p], 32'h0);
            wreg(fall_a[p] + 32'h4, 32'h0);
         end
      end
      $display("test edges done");
      rreg(EIF_ADDR_IRQ_STAT, 32'h1f);
      wreg(EIF_ADDR_IRQ_EN, 32'h10);
      repeat (3) @(posedge core_clk);
      check(irq, 32'h1);
      wreg(EIF_ADDR_IRQ_CLR, 32'h10);
      repeat (3) @(posedge core_clk);
      check(irq, 32'h0);
      wreg(EIF_ADDR_IRQ_STAT, 32'hff);
      rreg(EIF_ADDR_IRQ_STAT, 32'h0f);
      wreg(EIF_ADDR_IRQ_CLR, 32'h0f);
      rreg(EIF_ADDR_IRQ_STAT, 32'h0);
      $display("test interrupts done");
      // digital filter on each sampling clock; wait and clear pending after a change
      wreg(EIF_ADDR_LOW_RISE, 32'h40);
      for (int k = 0; k < 6; k++) begin
         wreg(EIF_ADDR_NFC, 32'h80 | 32'(k));
         repeat (4 * per[k]) @(posedge core_clk);
         wreg(EIF_ADDR_IRQ_CLR, 32'h01);
         clr_cnt();
         eif_pins_model_inst.drive(0, 1'b1, per[k]);
         check(cnt[0], 32'h0);
         repeat (4 * per[k]) @(posedge core_clk);
         check(cnt[0], 32'h1);
         eif_pins_model_inst.drive(0, 1'b0, 4 * per[k] + 8);
      end
      clr_cnt();
      eif_pins_model_inst.drive(0, 1'b1, per[5] + 4);
      eif_pins_model_inst.drive(0, 1'b0, 80);
      check(cnt[0], 32'h0);
      $display("test filter done");
      standby <= 1'b1;
      clr_cnt();
      eif_pins_model_inst.drive(0, 1'b1, 60);
      check(wake_cnt, 32'h1);
      eif_pins_model_inst.drive(0, 1'b0, 60);
      wreg(EIF_ADDR_NFC, 32'h80);
      clr_cnt();
      eif_pins_model_inst.drive(0, 1'b1, 300);
      check(cnt[0], 32'h0);
      standby <= 1'b0;
      repeat (300) @(posedge core_clk);
      check(cnt[0], 32'h1);
      check(irq, 32'h0);
      $display("test standby done");
      end_of_test();
   end
endmodule
bind eif_top eif_top_assertions eif_top_assertions_inst (.core_clk_i, .rstn_i, .avs_read_i,
   .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .irq_req_o, .pin3_wake_o, .irq_o);
